/* vpc_top.sv */
// serial host port and io_processing_control_one register with its control outputs
`timescale 1ns/1ps
`default_nettype none
module vpc_top
  import vpc_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_CLOCK_EN,
  input wire logic I_HOST_SCLK,
  input wire logic I_HOST_CS_N,
  input wire logic I_HOST_SERIAL_IN,
  output logic O_HOST_SERIAL_OUT,
  input wire logic I_TIMING_FORMAT_SELECT_PIN,
  input wire logic I_ACTIVE_LINE_BLANK,
  input wire logic I_TRS_H_BIT,
  output var vpc_ctrl_s O_VIDEO_CONTROL,
  output logic O_H_BLANK
);

  // serial clock domain state
  logic link_clr;
  vpc_phase_e phase_r;
  logic [3:0] bit_cnt_r;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  vpc_cmd_s cmd_r;
  vpc_cmd_s cmd_nxt;
  logic [11:0] addr_r;
  logic word_done;
  logic read_busy_r;
  logic [15:0] wr_data_r;
  logic [11:0] wr_addr_r;
  logic wr_tgl_r;
  logic [15:0] rd_shift_r;
  logic rd_active_r;

  // core domain state
  logic wr_tgl_s1_r;
  logic wr_tgl_s2_r;
  logic wr_tgl_s3_r;
  logic busy_s1_r;
  logic busy_s2_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic [15:0] rd_hold_r;
  logic wr_strobe;
  logic fmt_cea;
  logic h_sel_trs;
  vpc_ctrl_s ctrl_out_nxt;

  // frame ends with chip select high or core reset
  assign link_clr = I_HOST_CS_N | ~I_RESETN;

  // shifted word and command view of the current word
  assign shift_nxt = {shift_r[14:0], I_HOST_SERIAL_IN};
  assign cmd_nxt = vpc_cmd_s'(shift_nxt);
  assign word_done = (bit_cnt_r == VPC_WORD_LAST_BIT);

  // bit counter and shift register, cleared between frames
  always_ff @(posedge I_HOST_SCLK or posedge link_clr)
  begin
    if (link_clr)
    begin
      bit_cnt_r <= VPC_BIT_CNT_RESET;
      shift_r <= 16'h0000;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 4'h1; // wraps every 16 bits
      shift_r <= shift_nxt;
    end
  end

  // frame phase: one command word, then data words
  always_ff @(posedge I_HOST_SCLK or posedge link_clr)
  begin
    if (link_clr)
    begin
      phase_r <= VPC_PH_COMMAND;
      cmd_r <= '0;
      addr_r <= VPC_ADDR_IO_PROC_ONE;
    end
    else if (word_done)
    begin
      case (phase_r)
        VPC_PH_COMMAND:
        begin
          phase_r <= VPC_PH_DATA;
          cmd_r <= cmd_nxt;
          addr_r <= cmd_nxt.addr;
        end
        VPC_PH_DATA:
        begin
          if (cmd_r.auto_inc)
          begin
            addr_r <= addr_r + VPC_ADDR_STEP;
          end
        end
        default:
        begin
          phase_r <= VPC_PH_COMMAND;
        end
      endcase
    end
  end

  // read in progress level, raised by the first command bit
  always_ff @(posedge I_HOST_SCLK or posedge link_clr)
  begin
    if (link_clr)
    begin
      read_busy_r <= 1'b0;
    end
    else if (phase_r == VPC_PH_COMMAND && bit_cnt_r == VPC_BIT_CNT_RESET)
    begin
      read_busy_r <= I_HOST_SERIAL_IN;
    end
  end

  // captured write word, kept across frames until the next one
  always_ff @(posedge I_HOST_SCLK or negedge I_RESETN)
  begin
    if (!I_RESETN)
    begin
      wr_data_r <= 16'h0000;
      wr_addr_r <= VPC_ADDR_IO_PROC_ONE;
      wr_tgl_r <= 1'b0;
    end
    else if (word_done && phase_r == VPC_PH_DATA && !cmd_r.read)
    begin
      wr_data_r <= shift_nxt;
      wr_addr_r <= addr_r;
      wr_tgl_r <= ~wr_tgl_r;
    end
  end

  // read word loaded and shifted on falling serial clock edges
  always_ff @(negedge I_HOST_SCLK or posedge link_clr)
  begin
    if (link_clr)
    begin
      rd_shift_r <= 16'h0000;
      rd_active_r <= 1'b0;
    end
    else if (phase_r == VPC_PH_DATA && cmd_r.read && bit_cnt_r == VPC_BIT_CNT_RESET)
    begin
      rd_shift_r <= (addr_r == VPC_ADDR_IO_PROC_ONE) ? rd_hold_r : VPC_READ_NONE;
      rd_active_r <= 1'b1;
    end
    else if (rd_active_r)
    begin
      rd_shift_r <= {rd_shift_r[14:0], 1'b0};
    end
  end

  // loop-through of serial input, read data replaces it while reading
  assign O_HOST_SERIAL_OUT = rd_active_r ? rd_shift_r[15] : I_HOST_SERIAL_IN;

  // crossings into the core clock
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      wr_tgl_s1_r <= 1'b0;
      wr_tgl_s2_r <= 1'b0;
      wr_tgl_s3_r <= 1'b0;
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end
    else if (I_CLOCK_EN)
    begin
      wr_tgl_s1_r <= wr_tgl_r;
      wr_tgl_s2_r <= wr_tgl_s1_r;
      wr_tgl_s3_r <= wr_tgl_s2_r;
      busy_s1_r <= read_busy_r;
      busy_s2_r <= busy_s1_r;
      pin_s1_r <= I_TIMING_FORMAT_SELECT_PIN;
      pin_s2_r <= pin_s1_r;
    end
  end

  // write event seen once per toggle
  assign wr_strobe = wr_tgl_s2_r ^ wr_tgl_s3_r;

  // next register value, reserved top bit never stored
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    if (wr_strobe && wr_addr_r == VPC_ADDR_IO_PROC_ONE)
    begin
      ctrl_nxt = wr_data_r & VPC_IO_PROC_ONE_WMASK;
    end
  end

  // control register
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      ctrl_r <= VPC_IO_PROC_ONE_RESET;
    end
    else if (I_CLOCK_EN)
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // read snapshot, frozen while a read frame is open
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      rd_hold_r <= VPC_IO_PROC_ONE_RESET;
    end
    else if (I_CLOCK_EN && !busy_s2_r)
    begin
      rd_hold_r <= ctrl_r;
    end
  end

  // effective timing format and blanking selection
  assign fmt_cea = ctrl_r[VPC_BIT_PIN_OVERRIDE] ? ctrl_r[VPC_BIT_TIMING_CEA]
                                                : pin_s2_r;
  assign h_sel_trs = ctrl_r[VPC_BIT_H_TRS_BASED] & ~fmt_cea;

  // control levels for the datapath
  always_comb
  begin
    ctrl_out_nxt.primary_reference_word_remap_off = ctrl_r[VPC_BIT_REF_REMAP_OFF];
    ctrl_out_nxt.error_flag_update_off = ctrl_r[VPC_BIT_ERR_FLAG_OFF];
    ctrl_out_nxt.error_check_insert_off = ctrl_r[VPC_BIT_ERR_CHECK_OFF];
    ctrl_out_nxt.ancillary_extract_off = ctrl_r[VPC_BIT_ANC_EXTRACT_OFF];
    ctrl_out_nxt.primary_illegal_code_remap_off = ctrl_r[VPC_BIT_ILLEGAL_REMAP_OFF];
    ctrl_out_nxt.primary_anc_checksum_insert_off = ctrl_r[VPC_BIT_ANC_CSUM_OFF];
    ctrl_out_nxt.primary_line_crc_insert_off = ctrl_r[VPC_BIT_LINE_CRC_OFF];
    ctrl_out_nxt.timing_format_cea = fmt_cea;
    ctrl_out_nxt.h_blank_trs_based = h_sel_trs;
  end

  // registered control and horizontal blanking outputs
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
    begin
      O_VIDEO_CONTROL <= '0;
      O_H_BLANK <= 1'b0;
    end
    else if (I_CLOCK_EN)
    begin
      O_VIDEO_CONTROL <= ctrl_out_nxt;
      if (h_sel_trs)
      begin
        O_H_BLANK <= I_TRS_H_BIT;
      end
      else
      begin
        O_H_BLANK <= I_ACTIVE_LINE_BLANK;
      end
    end
  end

endmodule : vpc_top
`default_nettype wire

/* vpc_pkg.sv */
// constants, types and layouts for the video processing control register bank
package vpc_pkg;

  // register map
  localparam logic [11:0] VPC_ADDR_IO_PROC_ONE = 12'h000;
  localparam logic [15:0] VPC_IO_PROC_ONE_RESET = 16'h0000;
  localparam logic [15:0] VPC_IO_PROC_ONE_WMASK = 16'h7fff;
  localparam logic [15:0] VPC_READ_NONE = 16'h0000;

  // field positions in io_processing_control_one
  localparam int VPC_BIT_REF_REMAP_OFF = 14;
  localparam int VPC_BIT_ERR_FLAG_OFF = 12;
  localparam int VPC_BIT_ERR_CHECK_OFF = 11;
  localparam int VPC_BIT_H_TRS_BASED = 10;
  localparam int VPC_BIT_ANC_EXTRACT_OFF = 9;
  localparam int VPC_BIT_PIN_OVERRIDE = 7;
  localparam int VPC_BIT_TIMING_CEA = 6;
  localparam int VPC_BIT_ILLEGAL_REMAP_OFF = 4;
  localparam int VPC_BIT_ANC_CSUM_OFF = 3;
  localparam int VPC_BIT_LINE_CRC_OFF = 2;

  // serial word framing
  localparam logic [3:0] VPC_BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] VPC_WORD_LAST_BIT = 4'hf;
  localparam logic [11:0] VPC_ADDR_STEP = 12'h001;

  // host wait times in tenths of ns, and core cycles they span
  localparam int VPC_CLK_PERIOD_PS = 5000;
  localparam int VPC_WR_WAIT_UNLOCKED_NS_X10 = 1000;
  localparam int VPC_RD_WAIT_27M_NS_X10 = 1484;
  localparam int VPC_CS_HOLD_UNLOCKED_NS_X10 = 4450;
  localparam int VPC_WR_WAIT_UNLOCKED_CYC =
    (VPC_WR_WAIT_UNLOCKED_NS_X10 * 100 + VPC_CLK_PERIOD_PS - 1) / VPC_CLK_PERIOD_PS;
  localparam int VPC_RD_WAIT_27M_CYC =
    (VPC_RD_WAIT_27M_NS_X10 * 100 + VPC_CLK_PERIOD_PS - 1) / VPC_CLK_PERIOD_PS;
  localparam int VPC_CS_HOLD_UNLOCKED_CYC =
    (VPC_CS_HOLD_UNLOCKED_NS_X10 * 100 + VPC_CLK_PERIOD_PS - 1) / VPC_CLK_PERIOD_PS;

  // frame phase on the serial clock
  typedef enum logic [1:0] {
    VPC_PH_COMMAND = 2'b01,
    VPC_PH_DATA = 2'b10
  } vpc_phase_e;

  // command word layout, MSB first on the wire
  typedef struct packed {
    logic read;
    logic [1:0] spare;
    logic auto_inc;
    logic [11:0] addr;
  } vpc_cmd_s;

  // control levels handed to the video datapath
  typedef struct packed {
    logic primary_reference_word_remap_off;
    logic error_flag_update_off;
    logic error_check_insert_off;
    logic ancillary_extract_off;
    logic primary_illegal_code_remap_off;
    logic primary_anc_checksum_insert_off;
    logic primary_line_crc_insert_off;
    logic timing_format_cea;
    logic h_blank_trs_based;
  } vpc_ctrl_s;

endpackage : vpc_pkg

/* vpc_asserts.sv */
// checker on the control register bank ports
`timescale 1ns/1ps
`default_nettype none
module vpc_asserts
  import vpc_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic I_HOST_CS_N,
  input wire logic I_HOST_SERIAL_IN,
  input wire logic O_HOST_SERIAL_OUT,
  input wire logic I_ACTIVE_LINE_BLANK,
  input wire logic I_TRS_H_BIT,
  input wire vpc_ctrl_s O_VIDEO_CONTROL,
  input wire logic O_H_BLANK
);
  logic hs;
  logic ce;
  // effective blanking source and timing format
  assign hs = O_VIDEO_CONTROL.h_blank_trs_based;
  assign ce = O_VIDEO_CONTROL.timing_format_cea;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);
  // no host frame for eight cycles
  sequence idle_s;
    I_HOST_CS_N [*8];
  endsequence
  a_loop_through: assert property
    (I_HOST_CS_N |-> O_HOST_SERIAL_OUT == I_HOST_SERIAL_IN) else $error("loop path");
  a_h_active_blank: assert property
    ($past(I_RESETN) && !hs && !$past(hs) |-> O_H_BLANK == $past(I_ACTIVE_LINE_BLANK))
    else $error("h from line blank");
  a_h_trs_blank: assert property
    ($past(I_RESETN) && hs && $past(hs) |-> O_H_BLANK == $past(I_TRS_H_BIT))
    else $error("h from trs bit");
  a_trs_only_fvh: assert property
    (hs |-> !ce) else $error("trs blank in cea");
  a_cea_h_blank: assert property
    ($past(I_RESETN) && ce && $past(ce) |-> O_H_BLANK == $past(I_ACTIVE_LINE_BLANK))
    else $error("h in cea");
  a_reset_clear: assert property
    ($rose(I_RESETN) |-> O_VIDEO_CONTROL == '0 && !O_H_BLANK) else $error("reset");
  a_ctrl_hold_idle: assert property
    (idle_s |=> $stable(O_VIDEO_CONTROL[8:2])) else $error("ctrl moved");
  a_hblank_quiet: assert property
    (!I_ACTIVE_LINE_BLANK && !I_TRS_H_BIT |=> !O_H_BLANK) else $error("h high");
endmodule : vpc_asserts
bind vpc_top vpc_asserts u_chk (
  .I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_HOST_CS_N(I_HOST_CS_N),
  .I_HOST_SERIAL_IN(I_HOST_SERIAL_IN), .O_HOST_SERIAL_OUT(O_HOST_SERIAL_OUT),
  .I_ACTIVE_LINE_BLANK(I_ACTIVE_LINE_BLANK), .I_TRS_H_BIT(I_TRS_H_BIT),
  .O_VIDEO_CONTROL(O_VIDEO_CONTROL), .O_H_BLANK(O_H_BLANK)
);
`default_nettype wire

/* vpc_host.sv */
// host model driving the serial port in bursts
`timescale 1ns/1ps
`default_nettype none
module vpc_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdin,
  input wire logic i_sdout
);
  // idle: clock still, not selected
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdin = 1'b0;
  end
  // one word msb first, return sampled at each rise
  task automatic word(input logic [15:0] w, input logic drv, output logic [15:0] r);
    for (int i = 15; i >= 0; i--)
    begin
      o_sdin = drv ? w[i] : ~o_sdin;
      #16 o_sclk = 1'b1;
      r[i] = i_sdout;
      #16 o_sclk = 1'b0;
    end
  endtask : word
  // frame: command, wait, data word, select hold
  task automatic xfer(input logic [15:0] c, input logic [15:0] d, output logic [15:0] r);
    o_cs_n = 1'b0;
    #2.3 word(c, 1'b1, r);
    #150 word(d, ~c[15], r);
    #430 o_cs_n = 1'b1;
    o_sdin = ~o_sdin;
    #100;
  endtask : xfer
  // auto-increment frame: command, then two data words
  task automatic xfer2(input logic [15:0] c, input logic [15:0] d0, input logic [15:0] d1,
                       output logic [15:0] r0, output logic [15:0] r1);
    o_cs_n = 1'b0;
    #2.3 word(c, 1'b1, r0);
    #150 word(d0, ~c[15], r0);
    #150 word(d1, ~c[15], r1);
    #430 o_cs_n = 1'b1;
    o_sdin = ~o_sdin;
    #100;
  endtask : xfer2
endmodule : vpc_host
`default_nettype wire

/* test_video_proc_control_register.sv */
// self-checking bench for the control register bank
`timescale 1ns/1ps
`default_nettype none
module test_video_proc_control_register;
  import vpc_pkg::*;
  logic clk, rst_n, clk_en, pin, blank, hbit, sclk, cs_n, sdin, sdout, hb;
  vpc_ctrl_s ctrl;
  logic [15:0] rd, rd2, e, f;
  int err_total, comparisons, cyc;
  // address, data written, word read back
  logic [15:0] regs [10][3] = '{'{16'h0000, 16'hffff, 16'h7fff},
    '{16'h0000, 16'h4000, 16'h4000}, '{16'h0000, 16'h1000, 16'h1000},
    '{16'h0000, 16'h0800, 16'h0800}, '{16'h0000, 16'h0200, 16'h0200},
    '{16'h0000, 16'h0010, 16'h0010}, '{16'h0000, 16'h0008, 16'h0008},
    '{16'h0000, 16'h0004, 16'h0004}, '{16'h0005, 16'hffff, 16'h0004},
    '{16'h0000, 16'ha123, 16'h2123}};
  // word written, {pin, blank, hbit} and {cea, trs based, h}
  logic [15:0] tim [5][2] = '{'{16'h0400, 16'h0013}, '{16'h0400, 16'h0054},
    '{16'h0480, 16'h0053}, '{16'h04c0, 16'h0025}, '{16'h0000, 16'h0021}};
  vpc_top DUT (
    .I_CLOCK(clk), .I_RESETN(rst_n), .I_CLOCK_EN(clk_en),
    .I_HOST_SCLK(sclk), .I_HOST_CS_N(cs_n), .I_HOST_SERIAL_IN(sdin),
    .O_HOST_SERIAL_OUT(sdout), .I_TIMING_FORMAT_SELECT_PIN(pin),
    .I_ACTIVE_LINE_BLANK(blank), .I_TRS_H_BIT(hbit),
    .O_VIDEO_CONTROL(ctrl), .O_H_BLANK(hb)
  );
  vpc_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdin(sdin), .i_sdout(sdout));
  // core clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
    comparisons++;
    if (s !== x)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      stop_test();
    end
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    pin = 1'b0;
    blank = 1'b0;
    hbit = 1'b0;
    repeat (3) @(negedge clk);
    chk("reset outputs", 16'h0000, {6'h00, ctrl, hb});
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    host.xfer(16'h8000, 16'h0000, rd);
    chk("reset word", 16'h0000, rd);
    foreach (regs[i])
    begin
      host.xfer({4'h0, regs[i][0][11:0]}, regs[i][1], rd);
      host.xfer(16'h8000, 16'h0000, rd);
      e = regs[i][2];
      chk("word", e, rd);
      f = {9'h000, e[14], e[12], e[11], e[9], e[4], e[3], e[2]};
      chk("ctrl", f, {9'h000, ctrl[8:2]});
    end
    host.xfer(16'h8005, 16'h0000, rd);
    chk("unmapped", 16'h0000, rd);
    foreach (tim[i])
    begin
      @(negedge clk);
      {pin, blank, hbit} = tim[i][1][6:4];
      host.xfer(16'h0000, tim[i][0], rd);
      repeat (8) @(negedge clk);
      chk("timing", {13'h0000, tim[i][1][2:0]}, {13'h0000, ctrl[1:0], hb});
    end
    // clock enable low holds a captured write until it rises
    clk_en = 1'b0;
    fork
      host.xfer(16'h0000, 16'h0200, rd);
      begin
        #1300;
        @(negedge clk);
        chk("frozen ctrl", 16'h0000, {9'h000, ctrl[8:2]});
        clk_en = 1'b1;
        repeat (10) @(negedge clk);
        chk("released ctrl", 16'h0008, {9'h000, ctrl[8:2]});
      end
    join
    // auto-increment wraps from the top address onto the register
    host.xfer2(16'h1fff, 16'hffff, 16'hd555, rd, rd2);
    host.xfer2(16'h9fff, 16'h0000, 16'h0000, rd, rd2);
    chk("auto first word", 16'h0000, rd);
    chk("auto second word", 16'h5555, rd2);
    @(negedge clk);
    chk("auto ctrl", 16'h0065, {9'h000, ctrl[8:2]});
    // mid-run reset clears the register and outputs
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    chk("mid reset outputs", 16'h0000, {6'h00, ctrl, hb});
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    host.xfer(16'h8000, 16'h0000, rd);
    chk("mid reset word", 16'h0000, rd);
    stop_test();
  end
endmodule : test_video_proc_control_register
`default_nettype wire
